// *** src/bucket_pkg.sv ***
/*
 * Constants for the input activity leaky bucket: register offsets, reset
 * values, field widths and the monitoring cycle timing.
 * Assumes a 50 MHz system clock and byte-wide register access.
 */
// Contract
// - Each faulty or erratic 128 ms cycle adds one to that input's accumulator.
// - One is removed after each 1, 2, 4 or 8 clean cycles, per decay setting.
// - Active alarm clears when accumulator falls to reset threshold, default four.
// - Accumulator saturates at programmed bucket size, default eight.
// - Alarm is raised when accumulator reaches the programmed set threshold.
package bucket_pkg;
    // ------------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------------
    localparam int NUM_INPUTS = 2;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_ALARM_SET_LEVEL   = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_CLEAR_LEVEL = 8'h51;
    localparam logic [ADDR_W-1:0] ADDR_BUCKET_CAPACITY   = 8'h52;
    localparam logic [ADDR_W-1:0] ADDR_DECAY_SELECT      = 8'h53;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_STATUS      = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_FILL_LEVEL_BASE   = 8'h55;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_ALARM_SET_LEVEL   = 8'h06;
    localparam logic [DATA_W-1:0] RST_ALARM_CLEAR_LEVEL = 8'h04;
    localparam logic [DATA_W-1:0] RST_BUCKET_CAPACITY   = 8'h08;
    localparam logic [1:0]        RST_DECAY_SELECT      = 2'h1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ          = 50_000_000;
    localparam int MON_CYCLE_MS      = 128;
    localparam int MON_CYCLE_CLOCKS  = CLOCK_HZ / 1000 * MON_CYCLE_MS;
    localparam int TIMER_W           = 23;
    localparam int RUN_W             = 4;
endpackage : bucket_pkg

// *** src/bucket_if.sv ***
/*
 * Carrier between the register/timer top and one bucket channel.
 * Assumes one instance per monitored input, all on the system clock.
 */
`timescale 1ns/10ps
interface bucket_if;
    import bucket_pkg::*;
    logic              cycle_end;   // Last clock of a monitoring cycle
    logic              fault;       // Fault pulse from the activity monitor
    logic [DATA_W-1:0] set_level;
    logic [DATA_W-1:0] clear_level;
    logic [DATA_W-1:0] capacity;
    logic [1:0]        decay_sel;
    logic [DATA_W-1:0] fill;        // Accumulator value
    logic              alarm;

    modport ctrl (output cycle_end, fault, set_level, clear_level, capacity, decay_sel,
                  input fill, alarm);
    modport chan (input cycle_end, fault, set_level, clear_level, capacity, decay_sel,
                  output fill, alarm);
endinterface : bucket_if

// *** src/bucket_channel.sv ***
/*
 * One leaky bucket: integrates per-cycle fault results into an accumulator
 * and drives an inactivity alarm with hysteresis.
 * Assumes cycle_end pulses once per monitoring cycle and fault pulses come
 * from logic on the same clock.
 */
`timescale 1ns/10ps
module bucket_channel (
    // System
    input wire logic clock,
    input wire logic nrst,
    // Top side
    bucket_if.chan   bif
);
    import bucket_pkg::*;

    logic              fault_seen;
    logic              next_fault_seen;
    logic [RUN_W-2:0]  clean_run;
    logic [RUN_W-2:0]  next_clean_run;
    logic [DATA_W-1:0] fill;
    logic [DATA_W-1:0] next_fill;
    logic              alarm;
    logic              next_alarm;
    logic              faulty;
    logic [RUN_W-1:0]  run_len;
    logic [RUN_W-1:0]  run_done;

    // ------------------------------------------------------------------
    // Bucket update
    // ------------------------------------------------------------------
    // A fault in the closing clock still counts for the closing cycle
    always_comb begin
        faulty          = fault_seen | bif.fault;
        run_len         = RUN_W'(1) << bif.decay_sel;
        run_done        = RUN_W'({1'b0, clean_run}) + RUN_W'(1);
        next_fault_seen = faulty;
        next_clean_run  = clean_run;
        next_fill       = fill;
        next_alarm      = alarm;
        if (bif.cycle_end) begin
            next_fault_seen = 1'b0;
            if (faulty) begin
                next_clean_run = '0;
                // Also pulls a fill above a newly lowered capacity back down
                if (fill >= bif.capacity) begin
                    next_fill = bif.capacity;
                end else begin
                    next_fill = fill + DATA_W'(1);
                end
            end else if (run_done >= run_len) begin
                next_clean_run = '0;
                if (fill != '0) begin
                    next_fill = fill - DATA_W'(1);
                end
            end else begin
                next_clean_run = run_done[RUN_W-2:0];
            end
            // Set wins if the thresholds are programmed to overlap
            if (next_fill >= bif.set_level) begin
                next_alarm = 1'b1;
            end else if (next_fill <= bif.clear_level) begin
                next_alarm = 1'b0;
            end
        end
    end

    // Registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fault_seen <= 1'b0;
            clean_run  <= '0;
            fill       <= '0;
            alarm      <= 1'b0;
        end else begin
            fault_seen <= next_fault_seen;
            clean_run  <= next_clean_run;
            fill       <= next_fill;
            alarm      <= next_alarm;
        end
    end

    assign bif.fill  = fill;
    assign bif.alarm = alarm;
endmodule : bucket_channel

// *** src/input_activity_leaky_bucket.sv ***
/*
 * Leaky bucket activity qualifier for the reference inputs: byte registers,
 * the monitoring cycle timer and one bucket channel per input.
 * Assumes fault pulses arrive from the activity monitor on the same clock,
 * and register accesses come from a byte-wide port on the same clock.
 */
`timescale 1ns/10ps
module input_activity_leaky_bucket #(
    parameter int CYCLE_CLOCKS = bucket_pkg::MON_CYCLE_CLOCKS
) (
    // System
    input  wire logic                                  clock,
    input  wire logic                                  nrst,
    // Register port
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    input  wire logic [bucket_pkg::ADDR_W-1:0]         reg_addr,
    input  wire logic [bucket_pkg::DATA_W-1:0]         reg_wdata,
    output logic      [bucket_pkg::DATA_W-1:0]         reg_rdata,
    // Activity monitor
    input  wire logic [bucket_pkg::NUM_INPUTS-1:0]     fault,
    // Alarms
    output logic      [bucket_pkg::NUM_INPUTS-1:0]     inactivity_alarm,
    output logic                                       cycle_tick
);
    import bucket_pkg::*;

    logic [DATA_W-1:0]     alarm_set_level;
    logic [DATA_W-1:0]     next_alarm_set_level;
    logic [DATA_W-1:0]     alarm_clear_level;
    logic [DATA_W-1:0]     next_alarm_clear_level;
    logic [DATA_W-1:0]     bucket_capacity;
    logic [DATA_W-1:0]     next_bucket_capacity;
    logic [1:0]            decay_select;
    logic [1:0]            next_decay_select;
    logic [DATA_W-1:0]     next_reg_rdata;
    logic [TIMER_W-1:0]    timer;
    logic [TIMER_W-1:0]    next_timer;
    logic                  cycle_end;
    logic [DATA_W-1:0]     fill_bus [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] alarm_bus;

    // ------------------------------------------------------------------
    // Monitoring cycle timer
    // ------------------------------------------------------------------
    // One cycle_end per monitoring cycle, shared by all channels
    always_comb begin
        cycle_end  = (timer == TIMER_W'(CYCLE_CLOCKS - 1));
        next_timer = cycle_end ? '0 : timer + TIMER_W'(1);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Writes take effect at the next cycle_end evaluation, not mid-cycle
    always_comb begin
        next_alarm_set_level   = alarm_set_level;
        next_alarm_clear_level = alarm_clear_level;
        next_bucket_capacity   = bucket_capacity;
        next_decay_select      = decay_select;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_ALARM_SET_LEVEL:   next_alarm_set_level   = reg_wdata;
                ADDR_ALARM_CLEAR_LEVEL: next_alarm_clear_level = reg_wdata;
                ADDR_BUCKET_CAPACITY:   next_bucket_capacity   = reg_wdata;
                ADDR_DECAY_SELECT:      next_decay_select      = reg_wdata[1:0];
                default:                ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses and unused bits read zero
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            next_reg_rdata = '0;
            case (reg_addr)
                ADDR_ALARM_SET_LEVEL:   next_reg_rdata = alarm_set_level;
                ADDR_ALARM_CLEAR_LEVEL: next_reg_rdata = alarm_clear_level;
                ADDR_BUCKET_CAPACITY:   next_reg_rdata = bucket_capacity;
                ADDR_DECAY_SELECT:      next_reg_rdata = {6'h00, decay_select};
                ADDR_ALARM_STATUS:      next_reg_rdata = DATA_W'(alarm_bus);
                default: begin
                    for (int i = 0; i < NUM_INPUTS; i++) begin
                        if (reg_addr == ADDR_FILL_LEVEL_BASE + ADDR_W'(i)) begin
                            next_reg_rdata = fill_bus[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            alarm_set_level   <= RST_ALARM_SET_LEVEL;
            alarm_clear_level <= RST_ALARM_CLEAR_LEVEL;
            bucket_capacity   <= RST_BUCKET_CAPACITY;
            decay_select      <= RST_DECAY_SELECT;
            reg_rdata         <= '0;
        end else begin
            alarm_set_level   <= next_alarm_set_level;
            alarm_clear_level <= next_alarm_clear_level;
            bucket_capacity   <= next_bucket_capacity;
            decay_select      <= next_decay_select;
            reg_rdata         <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Bucket channels
    // ------------------------------------------------------------------
    // Every channel shares the same thresholds, as the register map has one set
    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_chan
        bucket_if bif ();
        assign bif.cycle_end   = cycle_end;
        assign bif.fault       = fault[g];
        assign bif.set_level   = alarm_set_level;
        assign bif.clear_level = alarm_clear_level;
        assign bif.capacity    = bucket_capacity;
        assign bif.decay_sel   = decay_select;
        assign fill_bus[g]     = bif.fill;
        assign alarm_bus[g]    = bif.alarm;

        bucket_channel u_chan (
            .clock (clock),
            .nrst  (nrst),
            .bif   (bif.chan)
        );
    end

    assign inactivity_alarm = alarm_bus;
    assign cycle_tick       = cycle_end;
endmodule : input_activity_leaky_bucket

// *** dv/input_activity_leaky_bucket_assertions.sv ***
/*
 * Port checker for the leaky bucket top: cycle timing, alarm timing, read port.
 * Assumes it is bound to the top module; one clock domain.
 */
`timescale 1ns/10ps
module input_activity_leaky_bucket_assertions #(
    parameter int CYCLE_CLOCKS = 8
) (
    // System
    input wire logic                              clock,
    input wire logic                              nrst,
    // Register port
    input wire logic                              reg_rd,
    input wire logic [bucket_pkg::DATA_W-1:0]     reg_rdata,
    // Monitor and alarms
    input wire logic [bucket_pkg::NUM_INPUTS-1:0] fault,
    input wire logic [bucket_pkg::NUM_INPUTS-1:0] inactivity_alarm,
    input wire logic                              cycle_tick
);
    import bucket_pkg::*;
    int                    clk_cnt;
    logic [NUM_INPUTS-1:0] seen;
    logic [NUM_INPUTS-1:0] cyc_bad;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Fault at the tick edge itself still belongs to the ending cycle
    assign cyc_bad = seen | fault;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_cnt <= 0;
            seen    <= '0;
        end else begin
            clk_cnt <= cycle_tick ? 0 : clk_cnt + 1;
            seen    <= cycle_tick ? '0 : cyc_bad;
        end
    end
    property p_tick_spacing;
        cycle_tick |-> clk_cnt == CYCLE_CLOCKS - 1;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick came early");
    property p_tick_due;
        clk_cnt == CYCLE_CLOCKS - 1 |-> cycle_tick;
    endproperty
    a_tick_due: assert property (p_tick_due)
        else $error("tick missing");
    property p_alarm_hold;
        !cycle_tick |=> $stable(inactivity_alarm);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm moved between ticks");
    property p_alarm_rise;
        (inactivity_alarm & ~$past(inactivity_alarm)) != '0 |-> $past(cycle_tick)
            && (inactivity_alarm & ~$past(inactivity_alarm) & ~$past(cyc_bad)) == '0;
    endproperty
    a_alarm_rise: assert property (p_alarm_rise)
        else $error("alarm rose without a faulty cycle");
    property p_alarm_fall;
        (~inactivity_alarm & $past(inactivity_alarm)) != '0 |-> $past(cycle_tick);
    endproperty
    a_alarm_fall: assert property (p_alarm_fall)
        else $error("alarm fell off a tick");
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");
endmodule : input_activity_leaky_bucket_assertions

// *** dv/activity_monitor_model.sv ***
/*
 * Activity monitor stand-in: a fault level held for whole monitoring cycles.
 * Assumes cycle_tick from the bucket top on the same clock.
 */
`timescale 1ns/10ps
module activity_monitor_model (
    // System
    input  wire logic       clock,
    input  wire logic       nrst,
    // Bucket side
    input  wire logic       cycle_tick,
    input  wire logic [1:0] plan,
    output logic      [1:0] fault
);
    logic [1:0] cur;
    // Plan taken only at a tick, so no cycle is half faulty by accident
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur <= 2'h0;
        end else if (cycle_tick) begin
            cur <= plan;
        end
    end
    assign fault = cur;
endmodule : activity_monitor_model

// *** dv/input_activity_leaky_bucket_tb_top.sv ***
/*
 * Self-checking bench for the leaky bucket top, with a monitor model.
 * Assumes a short monitoring cycle set through CYCLE_CLOCKS.
 */
`timescale 1ns/10ps
module input_activity_leaky_bucket_tb_top;
    import bucket_pkg::*;
    localparam int CYC = 16;
    logic       clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tick;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, e1 = 8'h00;
    logic [1:0] fault, alarm, plan = 2'h0;
    int         error_cnt = 0, samples_checked = 0;
    always #10 clock = ~clock;
    input_activity_leaky_bucket #(.CYCLE_CLOCKS(CYC)) u_dut (.clock(clock), .nrst(nrst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .fault(fault), .inactivity_alarm(alarm), .cycle_tick(tick));
    activity_monitor_model u_mon (.clock(clock), .nrst(nrst), .cycle_tick(tick),
        .plan(plan), .fault(fault));
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(n, reg_rdata, exp);
    endtask : rchk
    // Plan lands at the next tick, so each call completes the previous call's cycle
    // Tick is looked at on falling edges only, never in the edge that moves it
    task automatic cyc(input logic [1:0] p);
        @(posedge clock);
        plan <= p;
        @(negedge clock);
        for (int i = 0; i < 2 * CYC && tick !== 1'b1; i++) begin
            @(negedge clock);
        end
        @(posedge clock);
    endtask : cyc
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rchk("set_level", ADDR_ALARM_SET_LEVEL, RST_ALARM_SET_LEVEL);
        rchk("clear_level", ADDR_ALARM_CLEAR_LEVEL, 8'h04);
        rchk("capacity", ADDR_BUCKET_CAPACITY, 8'h08);
        rchk("decay", ADDR_DECAY_SELECT, 8'h01);
        rchk("unmapped", 8'h60, 8'h00);
        wr(ADDR_ALARM_SET_LEVEL, 8'h5A);
        rchk("set_wr", ADDR_ALARM_SET_LEVEL, 8'h5A);
        wr(ADDR_ALARM_SET_LEVEL, RST_ALARM_SET_LEVEL);
        wr(ADDR_DECAY_SELECT, 8'hFF);
        rchk("decay_mask", ADDR_DECAY_SELECT, 8'h03);
        wr(ADDR_DECAY_SELECT, 8'h00);
        wr(ADDR_ALARM_STATUS, 8'hFF);
        rchk("status_ro", ADDR_ALARM_STATUS, 8'h00);
        // Input 0 faulty ten cycles: alarm at six, count stops at eight
        for (int k = 0; k <= 10; k++) begin
            cyc(k < 10 ? 2'h1 : 2'h0);
            if (k > 0) begin
                rchk("fill0", ADDR_FILL_LEVEL_BASE, (k > 8) ? 8'h08 : 8'(k));
                rchk("alarm", ADDR_ALARM_STATUS, {7'h0, (k >= 6)});
                chk("alarm_pin", {6'h00, alarm}, {7'h0, (k >= 6)});
            end
        end
        // Clean cycles drain one each; alarm holds until four
        for (int k = 1; k <= 8; k++) begin
            cyc(k == 8 ? 2'h2 : 2'h0);
            rchk("fill0", ADDR_FILL_LEVEL_BASE, 8'(8 - k));
            rchk("alarm", ADDR_ALARM_STATUS, {7'h0, ((8 - k) > 4)});
            chk("alarm_pin", {6'h00, alarm}, {7'h0, ((8 - k) > 4)});
        end
        rchk("fill1", ADDR_FILL_LEVEL_BASE + 8'h01, 8'h00);
        // Every decay setting: one off after 1, 2, 4, 8 clean cycles
        for (int d = 0; d < 4; d++) begin
            wr(ADDR_DECAY_SELECT, 8'(d));
            cyc(2'h2);
            cyc(2'h0);
            e1 = e1 + 8'h02;
            for (int j = 1; j <= (1 << d); j++) begin
                cyc(j == (1 << d) ? 2'h2 : 2'h0);
                e1 = (j == (1 << d)) ? e1 - 8'h01 : e1;
                rchk("fill1", ADDR_FILL_LEVEL_BASE + 8'h01, e1);
            end
        end
        // Smaller capacity clamps the count on the next faulty cycle; a set level
        // of three overlaps the clear level, and set must win
        wr(ADDR_BUCKET_CAPACITY, 8'h03);
        wr(ADDR_ALARM_SET_LEVEL, 8'h03);
        cyc(2'h0);
        rchk("fill1_cap", ADDR_FILL_LEVEL_BASE + 8'h01, 8'h03);
        rchk("alarm_set3", ADDR_ALARM_STATUS, 8'h02);
        chk("alarm_pin_set3", {6'h00, alarm}, 8'h02);
        wr(ADDR_ALARM_CLEAR_LEVEL, 8'hA5);
        rchk("clear_wr", ADDR_ALARM_CLEAR_LEVEL, 8'hA5);
        final_report();
    end
    // Run needs under 1000 clocks; cut a hang well beyond that
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        final_report();
    end
endmodule : input_activity_leaky_bucket_tb_top
bind input_activity_leaky_bucket input_activity_leaky_bucket_assertions #(
    .CYCLE_CLOCKS(CYCLE_CLOCKS)
) u_chk (
    .clock(clock), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault(fault), .inactivity_alarm(inactivity_alarm), .cycle_tick(cycle_tick)
);
